// >>> irc4_pkg.sv
package irc4_pkg;
  localparam logic [13:0] HIGH_IDX = 14'h0ef9;
  localparam logic [13:0] LOW_IDX = 14'h0efa;
  localparam logic [13:0] ENA_IDX = 14'h0efb;
  localparam logic [13:0] STAT_IDX = 14'h0efc;
  localparam int RATE_LSB = 11;
  localparam int RATE_MSB = 14;
  localparam int INT1_BIT = 15;
  localparam int INT2_BIT = 14;
  localparam int DEC1_BIT = 9;
  localparam int DEC2_BIT = 8;
  localparam int STAT_MIX_BIT = 0;
  localparam int STAT_HRSV_BIT = 1;
  localparam int STAT_LRSV_BIT = 2;
  localparam int STAT_LVL_LSB = 4;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [3:0] ENA_RST = 4'h0;
  localparam logic [3:0] RATE_SYS1 = 4'h0;
  localparam logic [3:0] RATE_SYS2 = 4'h1;
  localparam logic [3:0] RATE_SYS3 = 4'h2;
  localparam logic [3:0] RATE_SEC1 = 4'h8;
  localparam logic [3:0] RATE_SEC2 = 4'h9;
  localparam logic [1:0] CH_INT1 = 2'h0;
  localparam logic [1:0] CH_INT2 = 2'h1;
  localparam logic [1:0] CH_DEC1 = 2'h2;
  localparam logic [1:0] CH_DEC2 = 2'h3;
  localparam int BUF_DEPTH = 2;
endpackage

// >>> irc4_ctrl.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
module irc4_ctrl
  import irc4_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter int ADDR_W = 16
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [1:0] in_chan_i,
  input wire logic [SAMPLE_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [1:0] out_chan_o,
  output logic [SAMPLE_W-1:0] out_data_o,
  output logic [3:0] high_rate_select_o,
  output logic [3:0] low_rate_select_o,
  output logic [3:0] chan_enable_o,
  output logic secondary_domain_o
);

  function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                   input logic [13:0] idx);
    idx_hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  function automatic logic rate_reserved(input logic [3:0] c);
    rate_reserved = !(c == RATE_SYS1 || c == RATE_SYS2 ||
                      c == RATE_SYS3 || c == RATE_SEC1 ||
                      c == RATE_SEC2);
  endfunction

  function automatic logic rate_secondary(input logic [3:0] c);
    rate_secondary = (c == RATE_SEC1 || c == RATE_SEC2);
  endfunction

  // register bus
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [3:0] high_sel_reg;
  logic [3:0] high_sel_next;
  logic [3:0] low_sel_reg;
  logic [3:0] low_sel_next;
  // index 0 int1, 1 int2, 2 dec1, 3 dec2
  logic [3:0] chan_en_reg;
  logic [3:0] chan_en_next;
  logic req;
  logic wr_take;
  logic lane1;
  logic [1:0] count_reg;

  assign req = avs_read_i | avs_write_i;
  // every access waits exactly one cycle
  assign avs_waitrequest_o = req & !ack_reg;
  assign wr_take = avs_write_i & ack_reg;
  assign lane1 = avs_byteenable_i[1];

  always_comb begin
    ack_next = req & !ack_reg;
    rdata_next = rdata_reg;
    high_sel_next = high_sel_reg;
    low_sel_next = low_sel_reg;
    chan_en_next = chan_en_reg;
    if (avs_read_i && !ack_reg) begin
      rdata_next = 32'h0000_0000;
      if (idx_hit(avs_address_i, HIGH_IDX)) begin
        rdata_next[RATE_MSB:RATE_LSB] = high_sel_reg;
      end else if (idx_hit(avs_address_i, LOW_IDX)) begin
        rdata_next[RATE_MSB:RATE_LSB] = low_sel_reg;
      end else if (idx_hit(avs_address_i, ENA_IDX)) begin
        rdata_next[INT1_BIT] = chan_en_reg[0];
        rdata_next[INT2_BIT] = chan_en_reg[1];
        rdata_next[DEC1_BIT] = chan_en_reg[2];
        rdata_next[DEC2_BIT] = chan_en_reg[3];
      end else if (idx_hit(avs_address_i, STAT_IDX)) begin
        rdata_next[STAT_MIX_BIT] =
          rate_secondary(high_sel_reg) != rate_secondary(low_sel_reg);
        rdata_next[STAT_HRSV_BIT] = rate_reserved(high_sel_reg);
        rdata_next[STAT_LRSV_BIT] = rate_reserved(low_sel_reg);
        rdata_next[STAT_LVL_LSB+1:STAT_LVL_LSB] = count_reg;
      end
    end
    if (wr_take && lane1) begin
      if (idx_hit(avs_address_i, HIGH_IDX)) begin
        high_sel_next = avs_writedata_i[RATE_MSB:RATE_LSB];
      end
      if (idx_hit(avs_address_i, LOW_IDX)) begin
        low_sel_next = avs_writedata_i[RATE_MSB:RATE_LSB];
      end
      if (idx_hit(avs_address_i, ENA_IDX)) begin
        chan_en_next[0] = avs_writedata_i[INT1_BIT];
        chan_en_next[1] = avs_writedata_i[INT2_BIT];
        chan_en_next[2] = avs_writedata_i[DEC1_BIT];
        chan_en_next[3] = avs_writedata_i[DEC2_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      high_sel_reg <= RATE_RST;
      low_sel_reg <= RATE_RST;
      chan_en_reg <= ENA_RST;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      high_sel_reg <= high_sel_next;
      low_sel_reg <= low_sel_next;
      chan_en_reg <= chan_en_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign high_rate_select_o = high_sel_reg;
  assign low_rate_select_o = low_sel_reg;
  assign chan_enable_o = chan_en_reg;
  // mixed domains are software's fault; the high rate picks the domain
  assign secondary_domain_o = rate_secondary(high_sel_reg);

  // per-channel two-tap stage
  logic push;
  logic pop;
  logic [SAMPLE_W-1:0] hist_reg [4];
  logic [SAMPLE_W-1:0] hist_next [4];
  logic [SAMPLE_W-1:0] filt;
  logic [SAMPLE_W:0] sum;

  assign push = in_valid_i & in_ready_o;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      always_comb begin
        hist_next[gi] = hist_reg[gi];
        if (!chan_en_reg[gi]) begin
          hist_next[gi] = '0;
        end else if (push && in_chan_i == 2'(gi)) begin
          hist_next[gi] = in_data_i;
        end
      end

      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          hist_reg[gi] <= '0;
        end else begin
          hist_reg[gi] <= hist_next[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    sum = {in_data_i[SAMPLE_W-1], in_data_i} +
          {hist_reg[in_chan_i][SAMPLE_W-1], hist_reg[in_chan_i]};
    if (chan_en_reg[in_chan_i]) begin
      filt = sum[SAMPLE_W:1];
    end else begin
      filt = '0;
    end
  end

  // two-entry output buffer
  logic [SAMPLE_W+1:0] mem_reg [BUF_DEPTH];
  logic [SAMPLE_W+1:0] mem_next [BUF_DEPTH];
  logic wptr_reg;
  logic wptr_next;
  logic rptr_reg;
  logic rptr_next;
  logic [1:0] count_next;

  assign in_ready_o = (count_reg != 2'(BUF_DEPTH));
  assign out_valid_o = (count_reg != 2'h0);
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wptr_reg] = {in_chan_i, filt};
      wptr_next = !wptr_reg;
    end
    if (pop) begin
      rptr_next = !rptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end

  assign out_chan_o = mem_reg[rptr_reg][SAMPLE_W+1:SAMPLE_W];
  assign out_data_o = mem_reg[rptr_reg][SAMPLE_W-1:0];

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  logic hi_wr;
  logic ena_wr;
  assign hi_wr = wr_take & lane1 & idx_hit(avs_address_i, HIGH_IDX);
  assign ena_wr = wr_take & lane1 & idx_hit(avs_address_i, ENA_IDX);

  high_field_a: assert property (
    hi_wr |=> high_rate_select_o == $past(avs_writedata_i[14:11]))
    else $error("high-rate select not taken from bits 14:11");

  low_field_a: assert property (
    wr_take && lane1 && idx_hit(avs_address_i, LOW_IDX)
    |=> low_rate_select_o == $past(avs_writedata_i[14:11]))
    else $error("low-rate select not taken from bits 14:11");

  interp_map_a: assert property (
    ena_wr |=> chan_enable_o[1:0] ==
      {$past(avs_writedata_i[14]), $past(avs_writedata_i[15])})
    else $error("interpolation enables not on bits 15 and 14");

  decim_map_a: assert property (
    ena_wr |=> chan_enable_o[3:2] ==
      {$past(avs_writedata_i[8]), $past(avs_writedata_i[9])})
    else $error("decimation enables not on bits 9 and 8");

  silent_out_a: assert property (
    push && !chan_en_reg[in_chan_i]
    |=> mem_reg[$past(wptr_reg)][SAMPLE_W-1:0] == '0)
    else $error("disabled channel produced a nonzero sample");

  state_clear_a: assert property (
    !chan_en_reg[0] && !chan_en_reg[3]
    |=> hist_reg[0] == '0 && hist_reg[3] == '0)
    else $error("disabled channel kept filter state");

  rate_hold_a: assert property (
    !hi_wr |=> $stable(high_rate_select_o))
    else $error("high-rate select changed without a write");

  low_hold_a: assert property (
    !(wr_take && lane1 && idx_hit(avs_address_i, LOW_IDX))
    |=> $stable(low_rate_select_o))
    else $error("low-rate select changed without a write");

  ena_hold_a: assert property (
    !ena_wr |=> $stable(chan_enable_o))
    else $error("channel enables changed without a write");

  mid_state_clear_a: assert property (
    !chan_en_reg[1] && !chan_en_reg[2]
    |=> hist_reg[1] == '0 && hist_reg[2] == '0)
    else $error("disabled channel kept filter state");

  bus_wait_a: assert property (
    req && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 !(req && !avs_waitrequest_o))
    else $error("access not answered after one wait cycle");

  buf_full_a: assert property (
    count_reg == 2'h2 |-> !in_ready_o && out_valid_o)
    else $error("full buffer still accepts data");

  cov_high_wr: cover property (hi_wr);
  cov_buf_full: cover property (!in_ready_o && in_valid_i);
  cov_mute: cover property (push && !chan_en_reg[in_chan_i]);
  cov_stat_rd: cover property (
    avs_read_i && ack_reg && idx_hit(avs_address_i, STAT_IDX));

endmodule

// >>> irc4_mix_model.sv
`timescale 1ns/1ns
// mixing engine side: sample source plus a receiver that can stall
module irc4_mix_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic in_ready_i,
  input wire logic hold_i,
  input wire logic slow_i,
  output logic in_valid_o,
  output logic [1:0] in_chan_o,
  output logic [23:0] in_data_o,
  output logic out_ready_o
);
  initial begin
    in_valid_o = 1'b0;
    in_chan_o = 2'h0;
    in_data_o = 24'h0;
    out_ready_o = 1'b1;
  end
  always @(posedge mclk_i) begin
    out_ready_o <= resetn_i && !hold_i && (slow_i ? !out_ready_o : 1'b1);
  end
  // word held until taken or for at most 50 cycles; data line garbled once released
  task automatic send(input logic [1:0] c, input logic [23:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    in_valid_o <= 1'b1;
    in_chan_o <= c;
    in_data_o <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (in_ready_i !== 1'b1 && n < 50);
    in_valid_o <= 1'b0;
    in_data_o <= ~d;
  endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
  import irc4_pkg::*;
  logic mclk_i = 0, resetn_i = 0, rd = 0, wr = 0, out_ready_i;
  logic hold = 0, slow = 0, in_valid_i, in_ready_o, out_valid_o, wq;
  logic [15:0] addr = 0, q, d;
  logic [31:0] wd = 0, rdata, st = 32'he7823b3c;
  logic [3:0] be = 0, hs, ls, ce, ena_q = 0;
  logic [1:0] in_chan_i, out_chan_o;
  logic [23:0] in_data_i, out_data_o, hist[4];
  logic [24:0] sum;
  logic [25:0] expq[$];
  logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
  logic sec;
  int mismatches = 0, checks = 0;
  always #10 mclk_i = ~mclk_i;
  irc4_ctrl irc4_ctrl_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wq), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .in_chan_i(in_chan_i), .in_data_i(in_data_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_chan_o(out_chan_o),
    .out_data_o(out_data_o), .high_rate_select_o(hs),
    .low_rate_select_o(ls), .chan_enable_o(ce), .secondary_domain_o(sec));
  irc4_mix_model irc4_mix_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .in_ready_i(in_ready_o), .hold_i(hold), .slow_i(slow),
    .in_valid_o(in_valid_i), .in_chan_o(in_chan_i),
    .in_data_o(in_data_i), .out_ready_o(out_ready_i));
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] i,
                     input logic [15:0] dd, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge mclk_i);
    addr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= {16'h0, dd};
    be <= b;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wq !== 1'b0);
    q = rdata[15:0];
    chk(32'(n), 32'h2);
    if (w && i == ENA_IDX && b[1]) ena_q = {dd[8], dd[9], dd[14], dd[15]};
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // expected stream result noted when a word is taken
  always @(posedge mclk_i) begin
    if (resetn_i && in_valid_i === 1'b1 && in_ready_o === 1'b1) begin
      sum = {in_data_i[23], in_data_i} + {hist[in_chan_i][23], hist[in_chan_i]};
      expq.push_back({in_chan_i, ena_q[in_chan_i] ? sum[24:1] : 24'h0});
      hist[in_chan_i] = in_data_i;
    end
    for (int k = 0; k < 4; k++) if (!ena_q[k] || !resetn_i) hist[k] = 24'h0;
  end
  always @(posedge mclk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      if (expq.size() == 0) chk({out_chan_o, out_data_o}, 32'hdead);
      else chk({out_chan_o, out_data_o}, expq.pop_front());
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(0, HIGH_IDX + 14'(i), 16'h0, 4'hf);
      chk(q, 16'h0);
    end
    chk({hs, ls, ce}, 12'h0);
    $display("reset values done");
    // legal same-domain codes, no samples in flight
    for (int i = 0; i < 5; i++) begin
      d = 16'(xs());
      bus(1, HIGH_IDX, {d[15], codes[i], d[10:0]}, 4'h2);
      bus(1, LOW_IDX, {d[15], codes[i < 3 ? 2 - i : 7 - i], d[10:0]}, 4'h2);
      bus(0, HIGH_IDX, 16'h0, 4'hf);
      chk(q, {1'b0, codes[i], 11'h0});
      bus(0, LOW_IDX, 16'h0, 4'hf);
      chk(q, {1'b0, codes[i < 3 ? 2 - i : 7 - i], 11'h0});
      chk({hs, ls, sec}, {codes[i], codes[i < 3 ? 2 - i : 7 - i],
                          codes[i][3]});
    end
    bus(1, HIGH_IDX, 16'h0, 4'hd);
    bus(0, HIGH_IDX, 16'h0, 4'hf);
    chk(q, {1'b0, codes[4], 11'h0});
    bus(0, 14'h0100, 16'h0, 4'hf);
    chk(q, 16'h0);
    $display("rate selects done");
    for (int i = 0; i < 6; i++) begin
      d = 16'(xs());
      bus(1, ENA_IDX, d, 4'h2);
      bus(0, ENA_IDX, 16'h0, 4'hf);
      chk(q, d & 16'hc300);
      chk(ce, {d[8], d[9], d[14], d[15]});
    end
    $display("enables done");
    bus(1, ENA_IDX, 16'h8200, 4'h2);
    slow <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      d = 16'(xs());
      irc4_mix_model_i.send(d[1:0], 24'(xs()));
    end
    hold <= 1'b1;
    for (int i = 0; i < 2; i++) irc4_mix_model_i.send(2'(i), 24'(xs()));
    repeat (2) @(posedge mclk_i);
    chk(in_ready_o, 1'b0);
    bus(0, STAT_IDX, 16'h0, 4'hf);
    chk(q, 16'h0020);
    hold <= 1'b0;
    slow <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk({out_valid_o, 4'(expq.size())}, 5'h0);
    $display("stream done");
    end_of_test();
  end
endmodule
